// file: bench/host_link.sv
/*
  Host controller model for the converter readout link: drives the
  convert strobe, the shift clock and the serial input, and samples
  the serial output.
  Assumes ref_clk at 25 MHz; every pin changes at a falling edge of it.
*/
`timescale 1ns/1ps
`default_nettype none

module host_link (
  // System clock, used only for pacing
  input wire logic ref_clk,
  // Pins toward the converter
  output logic convert_strobe,
  output logic shift_clk,
  output logic serial_in,
  // Pins from the converter
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  // -------------------------------------
  // Idle levels
  // -------------------------------------
  // Shift clock stands low between frames
  initial begin
    convert_strobe = 1'b0;
    shift_clk = 1'b0;
    serial_in = 1'b1;
  end

  // -------------------------------------
  // Pin tasks
  // -------------------------------------
  // Wait n falling edges of the system clock
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : tick

  // Move the strobe after an edge
  task automatic set_strobe(input logic v);
    tick(1);
    convert_strobe = v;
  endtask : set_strobe

  // Move the serial input after an edge
  task automatic set_in(input logic v);
    tick(1);
    serial_in = v;
  endtask : set_in

  // Start a conversion; sel high picks select mode
  task automatic start(input logic sel);
    tick(1);
    convert_strobe = 1'b0;
    serial_in = sel;
    tick(6);
    convert_strobe = 1'b1;
    tick(6);
  endtask : start

  // Read n bits at 320 ns per shift clock, feeding serial_in MSB first
  // Strobe is left as the caller set it, high for chain reads
  task automatic read_bits(input int n, input logic [31:0] feed, output logic [31:0] got);
    got = 32'h0000_0000;
    for (int k = 0; k < n; k++) begin
      tick(1);
      shift_clk = 1'b1;
      serial_in = feed[n-1-k];
      tick(4);
      // Sample just before the fall that moves the output on
      got = {got[30:0], serial_out};
      shift_clk = 1'b0;
      tick(3);
    end
  endtask : read_bits
endmodule : host_link

`default_nettype wire

// file: bench/test_adc_serial_readout_modes.sv
/*
  Self-checking bench for the converter readout block: select mode,
  chain mode, clamping and filling and draining the result buffer.
  Assumes the host_link model and the design's adc_pkg constants.
*/
`timescale 1ns/1ps
`default_nettype none

module test_adc_serial_readout_modes;
  import adc_pkg::*;
  // -------------------------------------
  // Signals
  // -------------------------------------
  logic ref_clk; // System clock
  logic rst_b; // Active low reset
  logic convert_strobe, shift_clk, serial_in; // From host model
  logic serial_out, serial_out_oe, conv_busy; // From design
  logic [RES_W-1:0] sample_code; // Front end code
  logic sample_over, sample_under; // Range flags
  int err_count, compares, cycles;
  logic [RES_W-1:0] exp_q[$]; // Expected buffered results
  logic [31:0] got; // Bits read back
  logic idle; // Sequencer went idle
  logic [15:0] cw; // Chain word fed upstream

  // -------------------------------------
  // Clock, model and design
  // -------------------------------------
  initial ref_clk = 1'b0;
  always #20 ref_clk = ~ref_clk;

  host_link host_u (.ref_clk(ref_clk), .convert_strobe(convert_strobe), .shift_clk(shift_clk),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe));

  adc_readout dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .convert_strobe(convert_strobe),
    .shift_clk(shift_clk), .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .sample_code(sample_code), .sample_over(sample_over),
    .sample_under(sample_under), .conv_busy(conv_busy));

  // -------------------------------------
  // Checking helpers
  // -------------------------------------
  // Expected output code after clamping
  function automatic logic [15:0] exp_code(input logic [15:0] c, input logic o, input logic u);
    return o ? RES_FULL : (u ? RES_ZERO : c);
  endfunction : exp_code

  // Compare a result word
  task automatic check_word(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check_word

  // Compare a single pin or flag
  task automatic check_bit(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check_bit

  // Verdict and end of run
  task automatic conclude();
    if (err_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  // Cut a hang short
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      conclude();
    end
  end

  // -------------------------------------
  // Scenario tasks
  // -------------------------------------
  // Present a sample and start a conversion, expect busy soon after
  task automatic convert(input logic sel, input logic [15:0] c, input logic o, input logic u);
    @(negedge ref_clk);
    sample_code = c;
    sample_over = o;
    sample_under = u;
    host_u.start(sel);
    for (int i = 0; i < 20 && conv_busy !== 1'b1; i++) @(negedge ref_clk);
    check_bit(conv_busy, 1'b1);
  endtask : convert

  // Bounded wait for the sequencer to finish
  task automatic wait_idle();
    for (int i = 0; i < 40 && conv_busy !== 1'b0; i++) @(negedge ref_clk);
    idle = (conv_busy === 1'b0);
    host_u.tick(4);
  endtask : wait_idle

  // One select mode conversion and readout
  task automatic sel_read(input logic [15:0] c, input logic o, input logic u);
    logic [15:0] e;
    e = exp_code(c, o, u);
    convert(1'b1, c, o, u);
    wait_idle();
    check_bit(idle, 1'b1);
    check_bit(serial_out_oe, 1'b0);
    host_u.set_in(1'b0);
    host_u.tick(6);
    check_bit(serial_out_oe, 1'b1);
    host_u.set_in(1'b1);
    host_u.tick(6);
    check_bit(serial_out_oe, 1'b0);
    host_u.set_strobe(1'b0);
    host_u.tick(6);
    check_bit(serial_out_oe, 1'b1);
    check_bit(serial_out, e[15]);
    host_u.read_bits(16, $urandom, got);
    check_word(got[15:0], e);
  endtask : sel_read

  // -------------------------------------
  // Main sequence
  // -------------------------------------
  initial begin
    logic [15:0] c;
    logic o;
    logic u;
    err_count = 0;
    compares = 0;
    rst_b = 1'b0;
    sample_code = 16'h0000;
    sample_over = 1'b0;
    sample_under = 1'b0;
    void'($urandom(32'h88c7bc43));
    repeat (3) @(negedge ref_clk);
    rst_b = 1'b1;
    // Select mode: clamp corners, midscale edges, then random codes
    for (int i = 0; i < 10; i++) begin
      c = 16'($urandom);
      if (i == 3) c = 16'h8000;
      if (i == 4) c = 16'h7fff;
      o = (i == 0 || i == 2) || (i > 4 && ($urandom % 4) == 0);
      u = (i == 1 || i == 2) || (i > 4 && ($urandom % 4) == 0);
      sel_read(c, o, u);
    end
    // Chain mode: own result first, then upstream word 16 clocks later
    c = 16'($urandom);
    cw = 16'($urandom);
    convert(1'b0, c, 1'b0, 1'b0);
    wait_idle();
    check_bit(serial_out_oe, 1'b1);
    check_bit(serial_out, c[15]);
    host_u.read_bits(32, {cw, 16'($urandom)}, got);
    check_word(got[31:16], c);
    check_word(got[15:0], cw);
    // Buffer: shifter plus 8 words, the tenth result stalls
    for (int i = 0; i < 10; i++) begin
      c = 16'($urandom);
      o = (($urandom % 4) == 0);
      u = (($urandom % 4) == 0);
      exp_q.push_back(exp_code(c, o, u));
      convert(1'b1, c, o, u);
      wait_idle();
      check_bit(idle, i < 9);
    end
    // Strobe while stalled is ignored, mode and sample both kept
    sample_code = 16'($urandom);
    sample_over = 1'($urandom);
    host_u.start(1'b0);
    host_u.set_in(1'b1);
    host_u.tick(6);
    check_bit(serial_out_oe, 1'b0);
    host_u.set_strobe(1'b0);
    host_u.tick(6);
    foreach (exp_q[i]) begin
      host_u.read_bits(16, $urandom, got);
      check_word(got[15:0], exp_q[i]);
    end
    host_u.tick(20);
    check_bit(conv_busy, 1'b0);
    conclude();
  end
endmodule : test_adc_serial_readout_modes

`default_nettype wire

// file: include/adc_pkg.sv
/*
  Shared constants and types for the converter readout block.
  Assumes a single 25 MHz system clock and a 16-bit result.
*/
// What this block does
// - Convert strobe rise starts conversion, latches mode
// - Serial input low at rise: daisy-chain mode
// - Serial input high at rise: select mode
// - Select mode: output driven only while enabled
// - Select mode: strobe or serial input low enables
// - Result shifted out one bit per shift clock
// - Chain mode: input reaches output 16 clocks later
// - Result presented most significant bit first
// - Output updates after each shift clock fall
// - Internal timer converts; shift clock only reads
// - Straight binary, clamped to all ones/zeros
`default_nettype none

package adc_pkg;

  // ----------------------------------------
  // Widths and sizes
  // ----------------------------------------
  localparam int RES_W = 16;             // Result width
  localparam int FIFO_DEPTH = 8;         // Result buffer depth
  localparam int BIT_CNT_W = 5;          // Holds 0..16
  localparam int SYNC_STAGES = 3;        // Pin synchroniser depth
  localparam int NUM_PINS = 3;           // Synchronised pins

  // ----------------------------------------
  // Pin positions in the synchroniser array
  // ----------------------------------------
  localparam int PIN_STB = 0;            // Convert strobe
  localparam int PIN_SCK = 1;            // Shift clock
  localparam int PIN_SIN = 2;            // Serial input

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 40;     // ref_clk period
  localparam int CONV_TIME_NS = 500;     // Internal conversion time
  localparam int CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CNT_W = $clog2(CONV_CYC + 1);

  // ----------------------------------------
  // Reset values and clamp codes
  // ----------------------------------------
  localparam logic [RES_W-1:0] RES_FULL = 16'hffff;  // Over-range code
  localparam logic [RES_W-1:0] RES_ZERO = 16'h0000;  // Under-range code
  localparam logic [SYNC_STAGES-1:0] SYNC_RST = 3'h0;
  localparam logic [NUM_PINS-1:0] FILT_RST = 3'h0;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic {MODE_CHAIN, MODE_SELECT} mode_t;
  typedef enum logic [1:0] {CV_IDLE, CV_RUN, CV_PUSH} conv_state_t;

endpackage : adc_pkg

`default_nettype wire

// file: include/fifo_if.sv
/*
  Valid/ready carrier between a result producer, the result
  buffer and the serial shifter. No clock inside.
*/
`timescale 1ns/1ps
`default_nettype none

interface fifo_if #(parameter int W = 16);
  logic in_valid;            // Producer has a word
  logic in_ready;            // Buffer can take a word
  logic [W-1:0] in_data;     // Word from producer
  logic out_valid;           // Buffer holds a word
  logic out_ready;           // Consumer takes the head
  logic [W-1:0] out_data;    // Head word

  // Producer side
  modport src (output in_valid, output in_data, input in_ready);
  // Buffer itself
  modport fifo (input in_valid, input in_data, output in_ready,
                output out_valid, output out_data, input out_ready);
  // Consumer side
  modport sink (input out_valid, input out_data, output out_ready);
endinterface : fifo_if

`default_nettype wire

// file: src/adc_readout.sv
/*
  Digital side of a 16-bit sampling converter: conversion
  start, mode selection and serial readout.
  Assumes host pins are asynchronous to ref_clk and the shift
  clock is slow enough to be oversampled (320 ns period).
*/
`timescale 1ns/1ps
`default_nettype none

module adc_readout
  import adc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Host link pins
  input wire logic convert_strobe,
  input wire logic shift_clk,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  // Sampled analog value, ref_clk domain
  input wire logic [RES_W-1:0] sample_code,
  input wire logic sample_over,
  input wire logic sample_under,
  // Status
  output logic conv_busy
);

  // --------------------------------------------
  // Declarations
  // --------------------------------------------
  localparam int CONV_PUSH_DLY = CONV_CYC + 1;  // Strobe to push

  logic [SYNC_STAGES-1:0] sync_r [NUM_PINS];  // Pin synchronisers
  logic [NUM_PINS-1:0] filt_r;                // Agreed pin levels
  logic [NUM_PINS-1:0] prev_r;                // Levels one cycle ago
  logic strobe_rise;                          // Strobe rising edge
  logic sck_fall;                             // Shift clock falling edge
  mode_t mode_r;                              // Latched interface mode
  conv_state_t conv_state_r;                  // Conversion sequencer
  logic [CONV_CNT_W-1:0] conv_cnt_r;          // Conversion timer
  logic [RES_W-1:0] conv_res_r;               // Captured result
  logic [RES_W-1:0] shift_r;                  // Output shifter
  logic [BIT_CNT_W-1:0] bit_cnt_r;            // Bits left of own result
  logic sh_busy_r;                            // Shifter holds own result
  logic oe_r;                                 // Output enable flop
  logic busy_r;                               // Conversion running
  logic start;                                // Accepted conversion start
  logic load;                                 // Shifter takes buffer head
  logic shift_en;                             // Shift on this fall

  fifo_if #(.W(RES_W)) buf_if ();             // Result path

  // --------------------------------------------
  // Helper functions
  // --------------------------------------------
  // Rising edge between two levels
  function automatic logic rise(input logic now, input logic was);
    rise = now && !was;
  endfunction : rise

  // Falling edge between two levels
  function automatic logic fall(input logic now, input logic was);
    fall = !now && was;
  endfunction : fall

  // Straight binary code with range clamp
  function automatic logic [RES_W-1:0] clamp(
    input logic [RES_W-1:0] code,
    input logic over,
    input logic under
  );
    if (over) begin
      clamp = RES_FULL;
    end else if (under) begin
      clamp = RES_ZERO;
    end else begin
      clamp = code;
    end
  endfunction : clamp

  // --------------------------------------------
  // Pin synchronisers
  // --------------------------------------------
  // Three stages; a level counts once stages two and three agree
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        sync_r[i] <= SYNC_RST;
      end
      filt_r <= FILT_RST;
    end else begin
      sync_r[PIN_STB] <= {sync_r[PIN_STB][1:0], convert_strobe};
      sync_r[PIN_SCK] <= {sync_r[PIN_SCK][1:0], shift_clk};
      sync_r[PIN_SIN] <= {sync_r[PIN_SIN][1:0], serial_in};
      for (int i = 0; i < NUM_PINS; i++) begin
        if (sync_r[i][1] == sync_r[i][2]) begin
          filt_r[i] <= sync_r[i][2];
        end
      end
    end
  end

  // Previous agreed levels for edge finding
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_r <= FILT_RST;
    end else begin
      prev_r <= filt_r;
    end
  end

  assign strobe_rise = rise(filt_r[PIN_STB], prev_r[PIN_STB]);
  assign sck_fall = fall(filt_r[PIN_SCK], prev_r[PIN_SCK]);
  // Strobe accepted only while no conversion is pending
  assign start = strobe_rise && (conv_state_r == CV_IDLE);

  // --------------------------------------------
  // Mode latch
  // --------------------------------------------
  // Serial input level at the accepted strobe edge picks the mode
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_r <= MODE_SELECT;
    end else if (start) begin
      if (filt_r[PIN_SIN]) begin
        mode_r <= MODE_SELECT;
      end else begin
        mode_r <= MODE_CHAIN;
      end
    end
  end

  a_mode_chain: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (start && !filt_r[PIN_SIN]) |=> (mode_r == MODE_CHAIN))
    else $error("Low serial input did not select chain mode");

  a_mode_select: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (start && filt_r[PIN_SIN]) |=> (mode_r == MODE_SELECT))
    else $error("High serial input did not select select mode");

  // --------------------------------------------
  // Conversion sequencer
  // --------------------------------------------
  // Internal timer; the shift clock plays no part here
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      conv_state_r <= CV_IDLE;
      conv_cnt_r <= '0;
      busy_r <= 1'b0;
    end else begin
      case (conv_state_r)
        // Wait for a strobe edge
        CV_IDLE: begin
          if (start) begin
            conv_cnt_r <= CONV_CNT_W'(CONV_CYC - 1);
            conv_state_r <= CV_RUN;
            busy_r <= 1'b1;
          end
        end
        // Count the conversion time
        CV_RUN: begin
          if (conv_cnt_r == '0) begin
            conv_state_r <= CV_PUSH;
          end else begin
            conv_cnt_r <= conv_cnt_r - 1'b1;
          end
        end
        // Hand result to the buffer; stalls while it is full
        CV_PUSH: begin
          if (buf_if.in_ready) begin
            conv_state_r <= CV_IDLE;
            busy_r <= 1'b0;
          end
        end
        default: begin
          conv_state_r <= CV_IDLE;
          busy_r <= 1'b0;
        end
      endcase
    end
  end

  // Sample captured at the strobe edge, clamped to range
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      conv_res_r <= RES_ZERO;
    end else if (start) begin
      conv_res_r <= clamp(sample_code, sample_over, sample_under);
    end
  end

  assign buf_if.in_valid = (conv_state_r == CV_PUSH);
  assign buf_if.in_data = conv_res_r;

  a_conv_timing: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    start |-> ##CONV_PUSH_DLY (conv_state_r == CV_PUSH))
    else $error("Conversion did not finish on time");

  a_clamp_over: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (start && sample_over) |=> (conv_res_r == RES_FULL))
    else $error("Over-range input not clamped to all ones");

  a_clamp_under: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (start && !sample_over && sample_under) |=> (conv_res_r == RES_ZERO))
    else $error("Under-range input not clamped to all zeros");

  // --------------------------------------------
  // Result buffer
  // --------------------------------------------
  result_fifo #(
    .W(RES_W),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clk(ref_clk),
    .rst_b(rst_b),
    .port(buf_if)
  );

  // --------------------------------------------
  // Serial shifter
  // --------------------------------------------
  // Next result is taken only once the previous one has left
  assign buf_if.out_ready = !sh_busy_r;
  assign load = buf_if.out_valid && !sh_busy_r;
  // Chain mode always shifts; select mode only while enabled
  assign shift_en = sck_fall && ((mode_r == MODE_CHAIN) || oe_r);

  // Load MSB first, then move one bit per falling shift edge
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_r <= RES_ZERO;
    end else if (load) begin
      shift_r <= buf_if.out_data;
    end else if (shift_en) begin
      if (mode_r == MODE_CHAIN) begin
        shift_r <= {shift_r[RES_W-2:0], filt_r[PIN_SIN]};
      end else begin
        shift_r <= {shift_r[RES_W-2:0], 1'b0};
      end
    end
  end

  // Count own bits out; frees the shifter for the next word
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt_r <= '0;
      sh_busy_r <= 1'b0;
    end else if (load) begin
      bit_cnt_r <= BIT_CNT_W'(RES_W);
      sh_busy_r <= 1'b1;
    end else if (shift_en && sh_busy_r) begin
      bit_cnt_r <= bit_cnt_r - 1'b1;
      if (bit_cnt_r == 5'h01) begin
        sh_busy_r <= 1'b0;
      end
    end
  end

  a_load_msb: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    load |=> (serial_out == $past(buf_if.out_data[RES_W-1])))
    else $error("Most significant bit not presented first");

  a_shift_on_fall: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    !$stable(shift_r) |-> $past(sck_fall || load))
    else $error("Output moved without a shift clock fall");

  a_chain_forward: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (shift_en && !load && mode_r == MODE_CHAIN) |=>
      (shift_r[0] == $past(filt_r[PIN_SIN])))
    else $error("Chain input not forwarded into the shifter");

  // --------------------------------------------
  // Output enable
  // --------------------------------------------
  // Select mode: strobe low or serial input low drives the pin
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      oe_r <= 1'b0;
    end else if (mode_r == MODE_SELECT) begin
      oe_r <= !(filt_r[PIN_STB] && filt_r[PIN_SIN]);
    end else begin
      oe_r <= 1'b1;  // Chain mode drives throughout
    end
  end

  a_oe_off: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (mode_r == MODE_SELECT && filt_r[PIN_STB] && filt_r[PIN_SIN])
      |=> !serial_out_oe)
    else $error("Output driven with strobe and serial input high");

  a_oe_on: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (mode_r == MODE_SELECT && !(filt_r[PIN_STB] && filt_r[PIN_SIN]))
      |=> serial_out_oe)
    else $error("Output not enabled by a low enable line");

  // --------------------------------------------
  // Outputs, all straight from flops
  // --------------------------------------------
  assign serial_out = shift_r[RES_W-1];
  assign serial_out_oe = oe_r;
  assign conv_busy = busy_r;

endmodule : adc_readout

`default_nettype wire

// file: src/result_fifo.sv
/*
  Flip-flop result buffer with valid/ready on both sides.
  Assumes push and pop come from the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module result_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Buffer ports
  fifo_if.fifo port
);

  localparam int PW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(D - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(D);

  logic [W-1:0] mem_r [D];   // Storage
  logic [PW-1:0] wr_ptr_r;   // Write index
  logic [PW-1:0] rd_ptr_r;   // Read index
  logic [CW-1:0] count_r;    // Words held
  logic push;                // Write this cycle
  logic pop;                 // Read this cycle

  // Pointer step with wrap
  function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
    step = (p == PTR_LAST) ? '0 : p + 1'b1;
  endfunction : step

  // Honest full and empty
  assign port.in_ready = (count_r != CNT_FULL);
  assign port.out_valid = (count_r != '0);
  assign port.out_data = mem_r[rd_ptr_r];
  assign push = port.in_valid && port.in_ready;
  assign pop = port.out_valid && port.out_ready;

  // Storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= port.in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= step(wr_ptr_r);
      end
      if (pop) begin
        rd_ptr_r <= step(rd_ptr_r);
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule : result_fifo

`default_nettype wire
